/* hw/ibc_pkg.sv */
// Constants, types and state record of the two-wire bus controller
package ibc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and bus answers
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  ADDR_CTRL_A    = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_B    = 4'h4;
    localparam logic [3:0]  ADDR_DBR       = 4'h8;
    localparam logic [3:0]  ADDR_OAR       = 4'hC;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          CA_BC_LO       = 5;
    localparam int          CA_ACK         = 4;
    localparam int          CB_MST         = 7;
    localparam int          CB_TRX         = 6;
    localparam int          CB_BB          = 5;
    localparam int          CB_PIN         = 4;
    localparam int          CB_MODE_LO     = 2;
    localparam int          OAR_ALS        = 0;
    localparam logic [1:0]  MODE_TWO_WIRE  = 2'h2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_A_RST     = 8'h00;
    localparam logic [7:0]  OAR_RST        = 8'h00;
    localparam logic [7:0]  DBR_RST        = 8'h00;
    localparam logic [1:0]  MODE_RST       = 2'h0;

    // ------------------------------------------------------------------
    // Timing: one bus half period (scl_release_delay)
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ        = 100;
    localparam int          T_HALF_NS      = 5000;
    localparam int          T_HALF_CYC     = (T_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int          TMR_W          = 10;

    // ------------------------------------------------------------------
    // Master clock phases
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        P_IDLE  = 5'h01,
        P_START = 5'h02,
        P_LOW   = 5'h04,
        P_HIGH  = 5'h08,
        P_STOP  = 5'h10
    } ibc_phase_t;

    typedef struct packed {
        logic             scl_s1, scl_s2, scl_q;
        logic             sda_s1, sda_s2, sda_q;
        logic [7:0]       ctrl_a, oar, shreg;
        logic             master_select, transmit_select, bb, pin, al, address_matched_flag, ad0, last_received_bit_flag;
        logic [1:0]       mode, swrst;
        logic [3:0]       cnt;
        logic             first, addressed, lost, dir, stop_req, hold;
        logic             sda_drv, scl_drv, scl_oe, irq;
        ibc_phase_t       phase;
        logic [TMR_W-1:0] tmr;
        logic             aw_rdy, bvalid, ar_rdy, rvalid;
        logic [1:0]       bresp, rresp;
        logic [31:0]      rdata;
    } ibc_state_t;

    localparam ibc_state_t ST_RST = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1,
        ctrl_a: CTRL_A_RST, oar: OAR_RST, shreg: DBR_RST,
        pin: 1'b1, mode: MODE_RST, phase: P_IDLE,
        default: '0
    };

endpackage

/* hw/ibc_ctrl.sv */
// Two-wire serial bus controller with AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Functional notes
// - Address mode compares received address with own_slave_address bits 7..1.
// - Free format: no address recognition; every byte after start is data.
// - master_select bit 7, transmit_select bit 6 of control_reg_b.
// - Stop detection or arbitration loss clears master and transmit select.
// - Addressed slave copies received direction bit into transmit_select.
// - Master: acknowledged address sets transmit_select to inverted direction.
// - Free format: hardware never sets transmit_select from the direction bit.
// - Bus free, write 1 to mst/trx/bb/pin: start and address byte sent.
// - Bus busy, write bb=0 others 1: stop, after clock line released.
// - bus_busy_flag set on any start, cleared on any stop.
// - Master raises transfer_irq after bit count plus acknowledge clock.
// - Slave raises transfer_irq after address match ack and each byte.
// - transfer_irq clears service_pending_n except after lost arbitration; clock held low while it is 0.
// - Buffer access or write of 1 sets pending bit; release after delay.
// - Lost arbitration, unmatched address: irq raised, pending bit kept 1.
// - Data mismatch at clock rise: flag set, become slave, release lines.
// - Buffer access or control_reg_b write clears arbitration_lost_flag.
// - address_matched_flag on match, general call, free-format first byte.
// - general_call_flag set by all-zero first byte, cleared on start/stop.
// - last_received_bit_flag samples data at each clock rise.
// - Start clears bit_count_field so address byte is eight bits.
// - Acknowledge mode adds one acknowledge clock to master and slave.
module ibc_ctrl
    import ibc_pkg::*;
#(
    parameter int HALF_CYC = T_HALF_CYC      // Clock half period in cycles
) (
    input  wire logic              aclk,     // System clock
    input  wire logic              aresetn,  // Synchronous reset
    input  wire logic [ADDR_W-1:0] awaddr,   // Write address
    input  wire logic              awvalid,  // Write address valid
    output logic                   awready,  // Write address ready
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic [3:0]        wstrb,    // Write byte strobes
    input  wire logic              wvalid,   // Write data valid
    output logic                   wready,   // Write data ready
    output logic [1:0]             bresp,    // Write response
    output logic                   bvalid,   // Write response valid
    input  wire logic              bready,   // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,   // Read address
    input  wire logic              arvalid,  // Read address valid
    output logic                   arready,  // Read address ready
    output logic [31:0]            rdata,    // Read data
    output logic [1:0]             rresp,    // Read response
    output logic                   rvalid,   // Read data valid
    input  wire logic              rready,   // Read data ready
    input  wire logic              scl_i,    // Clock line level
    output logic                   scl_o,    // Clock line drive value
    output logic                   scl_oe,   // Clock line pulled low
    input  wire logic              sda_i,    // Data line level
    output logic                   sda_o,    // Data line drive value
    output logic                   sda_oe,   // Data line pulled low
    output logic                   transfer_irq // Transfer done pulse
);

    if (HALF_CYC < 1 || HALF_CYC >= (1 << TMR_W)) begin : g_chk
        $error("HALF_CYC out of range");
    end

    localparam logic [TMR_W-1:0] HALF = TMR_W'(HALF_CYC);

    ibc_state_t s;
    ibc_state_t n;

    // ------------------------------------------------------------------
    // Register select: one-hot {unmapped, oar, dbr, ctrl_b, ctrl_a}
    // ------------------------------------------------------------------
    function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [3:0] w;
        w = {a[3:2], 2'b00};
        case (w)
            ADDR_CTRL_A: reg_sel = 5'h01;
            ADDR_CTRL_B: reg_sel = 5'h02;
            ADDR_DBR:    reg_sel = 5'h04;
            ADDR_OAR:    reg_sel = 5'h08;
            default:     reg_sel = 5'h10;
        endcase
    endfunction

    logic [4:0] wsel;
    logic [4:0] rsel;
    logic       wr_go;
    logic       rd_go;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [3:0] nbits;
    logic [3:0] tot;
    logic [3:0] c1;
    logic [7:0] status;

    assign wsel      = reg_sel(awaddr);
    assign rsel      = reg_sel(araddr);
    assign wr_go     = s.aw_rdy & awvalid & wvalid;
    assign rd_go     = s.ar_rdy & arvalid;
    assign scl_rise  = s.scl_s2 & ~s.scl_q;
    assign scl_fall  = ~s.scl_s2 & s.scl_q;
    assign start_det = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
    assign stop_det  = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
    assign nbits     = (s.ctrl_a[7:5] == 3'h0) ? 4'h8
                                               : {1'b0, s.ctrl_a[7:5]};
    assign tot       = nbits + {3'h0, s.ctrl_a[CA_ACK]};
    assign c1        = s.cnt + 4'h1;
    assign status    = {s.master_select, s.transmit_select, s.bb, s.pin,
                        s.al, s.address_matched_flag, s.ad0, s.last_received_bit_flag};

    always_comb begin
        n = s;
        n.irq = 1'b0;
        // --------------------------------------------------------------
        // Line synchronisers
        // --------------------------------------------------------------
        n.scl_s1 = scl_i;
        n.scl_s2 = s.scl_s1;
        n.scl_q  = s.scl_s2;
        n.sda_s1 = sda_i;
        n.sda_s2 = s.sda_s1;
        n.sda_q  = s.sda_s2;
        if (s.tmr != '0) begin
            n.tmr = s.tmr - TMR_W'(1);
        end

        // --------------------------------------------------------------
        // AXI4-Lite slave
        // --------------------------------------------------------------
        n.aw_rdy = ~s.aw_rdy & awvalid & wvalid & ~s.bvalid;
        n.ar_rdy = ~s.ar_rdy & arvalid & ~s.rvalid;
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp  = wsel[4] ? RESP_SLVERR : RESP_OKAY;
            if (wstrb[0]) begin
                if (wsel[0]) begin
                    n.ctrl_a = wdata[7:0];
                end
                if (wsel[3]) begin
                    n.oar = wdata[7:0];
                end
                if (wsel[2]) begin
                    n.shreg = wdata[7:0];
                    n.pin   = 1'b1;
                    n.al    = 1'b0;
                    n.address_matched_flag   = 1'b0;
                end
                if (wsel[1]) begin
                    n.al    = 1'b0;
                    n.mode  = wdata[CB_MODE_LO+1:CB_MODE_LO];
                    n.swrst = wdata[1:0];
                    if (wdata[CB_PIN]) begin
                        n.pin = 1'b1;
                    end
                    if (!s.bb && wdata[7:4] == 4'hF) begin
                        n.master_select     = 1'b1;
                        n.transmit_select     = 1'b1;
                        n.bb      = 1'b1;
                        n.dir     = s.shreg[0];
                        n.phase   = P_START;
                        n.sda_drv = 1'b1;
                        n.scl_drv = 1'b0;
                        n.tmr     = HALF;
                    end else if (s.bb && wdata[7:4] == 4'hD) begin
                        n.stop_req = 1'b1;
                    end else if (!s.bb) begin
                        n.master_select = wdata[CB_MST];
                        n.transmit_select = wdata[CB_TRX];
                    end
                end
            end
        end
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp  = rsel[4] ? RESP_SLVERR : RESP_OKAY;
            case (rsel)
                5'h01:   n.rdata = {24'h0, s.ctrl_a};
                5'h02:   n.rdata = {24'h0, status};
                5'h04:   n.rdata = {24'h0, s.shreg};
                5'h08:   n.rdata = {24'h0, s.oar};
                default: n.rdata = 32'h0;
            endcase
            if (rsel[2]) begin
                n.pin = 1'b1;
                n.al  = 1'b0;
                n.address_matched_flag = 1'b0;
            end
        end
        if (n.pin && !s.pin) begin
            n.tmr = HALF;
        end

        // --------------------------------------------------------------
        // Bus engine
        // --------------------------------------------------------------
        if (s.mode == MODE_TWO_WIRE) begin
            if (start_det) begin
                n.bb        = 1'b1;
                n.ad0       = 1'b0;
                n.ctrl_a[7:5] = 3'h0;
                n.cnt       = 4'h0;
                n.first     = 1'b1;
                n.addressed = 1'b0;
                n.lost      = 1'b0;
            end
            if (scl_rise) begin
                n.last_received_bit_flag = s.sda_s2;
                // Bits counted at clock rise: the start's fall is no bit
                if (s.bb) begin
                    n.cnt = c1;
                end
                if (s.cnt < nbits) begin
                    n.shreg = {s.shreg[6:0], s.sda_s2};
                    if (s.master_select && s.phase != P_IDLE && !s.sda_drv
                        && !s.sda_s2 && (s.first || s.transmit_select)) begin
                        n.al      = 1'b1;
                        n.master_select     = 1'b0;
                        n.transmit_select     = 1'b0;
                        n.lost    = 1'b1;
                        n.phase   = P_IDLE;
                        n.scl_drv = 1'b0;
                        n.sda_drv = 1'b0;
                        n.stop_req = 1'b0;
                    end
                end
            end
            if (scl_fall && s.bb) begin
                if (s.cnt == nbits && s.first && !s.master_select) begin
                    if (s.oar[OAR_ALS]) begin
                        n.address_matched_flag       = 1'b1;
                        n.addressed = 1'b1;
                    end else if (s.shreg == 8'h00) begin
                        n.ad0       = 1'b1;
                        n.address_matched_flag       = 1'b1;
                        n.addressed = 1'b1;
                    end else if (s.shreg[7:1] == s.oar[7:1]) begin
                        n.address_matched_flag       = 1'b1;
                        n.transmit_select       = s.shreg[0];
                        n.addressed = 1'b1;
                    end
                end
                if (s.cnt == tot) begin
                    n.cnt   = 4'h0;
                    n.first = 1'b0;
                    n.lost  = 1'b0;
                    if (s.master_select) begin
                        n.irq = 1'b1;
                        n.pin = 1'b0;
                        if (s.first && !s.last_received_bit_flag && s.ctrl_a[CA_ACK]
                            && !s.oar[OAR_ALS]) begin
                            n.transmit_select = ~s.dir;
                        end
                    end else if (n.addressed) begin
                        n.irq  = 1'b1;
                        n.pin  = 1'b0;
                        n.hold = 1'b1;
                    end else if (s.lost) begin
                        n.irq = 1'b1;
                    end
                end
                // Next bit to place on the data line
                if (n.cnt < nbits) begin
                    n.sda_drv = ~n.shreg[7] & (n.master_select ? (n.first | n.transmit_select)
                                : (n.addressed & n.transmit_select & ~n.first));
                end else if (n.master_select) begin
                    n.sda_drv = ~n.transmit_select & ~s.first;
                end else begin
                    n.sda_drv = n.addressed & (s.first | ~n.transmit_select);
                end
            end
            // Slave stretch released one low period after pending set
            if (s.hold && s.pin && s.tmr == '0) begin
                n.hold = 1'b0;
            end
            case (s.phase)
                P_IDLE: begin
                end
                P_START: begin
                    if (s.tmr == '0) begin
                        n.scl_drv = 1'b1;
                        n.phase   = P_LOW;
                        n.tmr     = HALF;
                        n.sda_drv = ~s.shreg[7];
                    end
                end
                P_LOW: begin
                    n.scl_drv = 1'b1;
                    if (!n.pin) begin
                        n.tmr = HALF;
                    end else if (s.stop_req) begin
                        n.sda_drv = 1'b1;
                        if (s.tmr == '0) begin
                            n.scl_drv = 1'b0;
                            n.phase   = P_STOP;
                            n.tmr     = HALF;
                        end
                    end else if (s.tmr == '0) begin
                        n.scl_drv = 1'b0;
                        n.phase   = P_HIGH;
                        n.tmr     = HALF;
                    end
                end
                P_HIGH: begin
                    if (scl_fall) begin
                        n.scl_drv = 1'b1;
                        n.phase   = P_LOW;
                        n.tmr     = HALF;
                    end else if (!s.scl_s2) begin
                        n.tmr = HALF;
                    end else if (s.tmr == '0) begin
                        n.scl_drv = 1'b1;
                        n.phase   = P_LOW;
                        n.tmr     = HALF;
                    end
                end
                P_STOP: begin
                    if (!s.scl_s2) begin
                        n.tmr = HALF;
                    end else if (s.tmr == '0) begin
                        n.sda_drv  = 1'b0;
                        n.phase    = P_IDLE;
                        n.stop_req = 1'b0;
                    end
                end
                default: begin
                    n.phase = P_IDLE;
                end
            endcase
            if (stop_det) begin
                n.bb        = 1'b0;
                n.master_select       = 1'b0;
                n.transmit_select       = 1'b0;
                n.ad0       = 1'b0;
                n.addressed = 1'b0;
                n.hold      = 1'b0;
                n.stop_req  = 1'b0;
                n.phase     = P_IDLE;
                n.scl_drv   = 1'b0;
                n.sda_drv   = 1'b0;
            end
        end else begin
            n.phase   = P_IDLE;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
            n.hold    = 1'b0;
        end
        n.scl_oe = n.scl_drv | n.hold;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready      = s.aw_rdy;
    assign wready       = s.aw_rdy;
    assign bvalid       = s.bvalid;
    assign bresp        = s.bresp;
    assign arready      = s.ar_rdy;
    assign rvalid       = s.rvalid;
    assign rdata        = s.rdata;
    assign rresp        = s.rresp;
    assign scl_oe       = s.scl_oe;
    assign sda_oe       = s.sda_drv;
    assign scl_o        = 1'b0;
    assign sda_o        = 1'b0;
    assign transfer_irq = s.irq;

endmodule // ibc_ctrl

/* test/ibc_ctrl_assertions.sv */
// Port checker of the bus controller
`timescale 1ns/1ps
module ibc_ctrl_checker (
    input wire logic aclk,        // Clock
    input wire logic aresetn,     // Reset
    input wire logic awready,     // AW taken
    input wire logic wready,      // W taken
    input wire logic bvalid,      // B valid
    input wire logic bready,      // B ready
    input wire logic arready,     // AR taken
    input wire logic rvalid,      // R valid
    input wire logic rready,      // R ready
    input wire logic scl_o,       // Clock value
    input wire logic scl_oe,      // Clock pulled
    input wire logic sda_o,       // Data value
    input wire logic transfer_irq // Transfer done
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    irq_pulse_a: assert property (transfer_irq |=> !transfer_irq)
        else $error("long pulse");
    scl_hold_a: assert property (transfer_irq && scl_oe |=> scl_oe[*3])
        else $error("clock released early");
    b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("b");
    r_hold_a: assert property (rvalid && !rready |=> rvalid) else $error("r");
    wr_pair_a: assert property (awready == wready) else $error("split");
    wr_resp_a: assert property (awready |=> bvalid) else $error("no b");
    rd_resp_a: assert property (arready |=> rvalid) else $error("no r");
    open_drain_a: assert property (!scl_o && !sda_o) else $error("driven");
endmodule // ibc_ctrl_checker
bind ibc_ctrl ibc_ctrl_checker u_chk (.aclk, .aresetn, .awready, .wready,
    .bvalid, .bready, .arready, .rvalid, .rready, .scl_o, .scl_oe, .sda_o,
    .transfer_irq);

/* test/ibc_bus_peer.sv */
// Bus peer that acknowledges its own address
`timescale 1ns/1ps
module ibc_bus_peer #(
    parameter logic [6:0] ADDR = 7'h53 // Answered address
) (
    input  wire logic scl,    // Clock line
    input  wire logic sda,    // Data line
    output logic      sda_oe  // Pulls data low
);
    logic [7:0] sh = '0;
    int         cnt = 9;
    always @(negedge sda) if (scl) cnt = 0;
    always @(posedge scl) if (cnt < 8) begin
        sh = {sh[6:0], sda};
        cnt++;
    end
    always @(negedge scl) begin
        sda_oe = (cnt == 8) && (sh[7:1] == ADDR);
        if (cnt == 8) cnt = 9;
    end
endmodule // ibc_bus_peer

/* test/tb.sv */
// Self-checking bench of the bus controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb import ibc_pkg::*;;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic        rvalid, transfer_irq, scl_oe, sda_oe, p_sda_oe;
    logic [3:0]  awaddr = '0, araddr = '0, wstrb = 4'hF;
    logic [31:0] wdata = '0, rdata;
    logic [7:0]  d;
    int          miscompares = 0, n_tests = 0;
    wire         scl = (scl_oe !== 1'b1);
    wire         sda = (sda_oe !== 1'b1) && (p_sda_oe !== 1'b1);
    always #5 aclk = ~aclk;
    ibc_ctrl #(.HALF_CYC(6)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp(), .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp(), .rvalid, .rready, .scl_i(scl),
        .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .transfer_irq);
    ibc_bus_peer #(.ADDR(7'h53)) peer (.scl, .sda, .sda_oe(p_sda_oe));
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tmo(input int i);
        if (i < 3000) return;
        `CHK("wait done", 1'b1, 1'b0)
        end_of_test();
    endtask
    task automatic axi(input logic w, input logic [3:0] a,
                       input logic [7:0] v, output logic [7:0] q);
        int i = 0;
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, 24'h0, v};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do @(posedge aclk); while (!(w ? awready : arready) && ++i < 3000);
        {awvalid, wvalid, arvalid} <= 3'b000;
        do @(posedge aclk); while (!(w ? bvalid : rvalid) && ++i < 3000);
        q = rdata[7:0];
        {bready, rready} <= 2'b00;
        tmo(i);
    endtask
    task automatic t_init();
        axi(1'b0, ADDR_CTRL_B, 8'h00, d);
        `CHK("status reset", 8'h10, d)
        axi(1'b1, ADDR_CTRL_A, 8'h10, d);
        axi(1'b1, ADDR_OAR, 8'h66, d);
        `CHK("lines high", 2'b11, {scl, sda})
        axi(1'b1, ADDR_CTRL_B, 8'h18, d);
    endtask
    task automatic t_master(input logic [7:0] b, input logic [7:0] e);
        int i = 0;
        axi(1'b1, ADDR_CTRL_A, 8'h30, d);
        axi(1'b1, ADDR_DBR, b, d);
        axi(1'b1, ADDR_CTRL_B, 8'hF8, d);
        while (transfer_irq !== 1'b1 && ++i < 3000) @(posedge aclk);
        tmo(i);
        axi(1'b0, ADDR_CTRL_B, 8'h00, d);
        `CHK("addr status", e, d)
        axi(1'b0, ADDR_CTRL_A, 8'h00, d);
        `CHK("bit count", 8'h10, d)
        axi(1'b1, ADDR_CTRL_B, 8'hD8, d);
        do axi(1'b0, ADDR_CTRL_B, 8'h00, d); while (d[5] && ++i < 3000);
        tmo(i);
        `CHK("stop status", 8'h10, d)
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_init();
        t_master(8'hA6, 8'hE0);
        t_master(8'hA7, 8'hA0);
        t_master(8'h20, 8'hE1);
        end_of_test();
    end
endmodule // tb
